// file: logic/ccs_regs.sv
// charger control/status register bank behind an i2c target
// assumes scl/sda already synchronous to core_clk; sda is open drain
//
// Functional notes
// RULE_01 - vout is 5 V plus 10 mV per code; vout_mv is 0 while the external divider is selected
// RULE_02 - voltage code staged until voltage load strobe
// RULE_03 - current limit and clamp staged until load
// RULE_04 - write-one strobes act once, read zero
// RULE_05 - clamp field sets minimum input current limit
// RULE_06 - battery current limit field, reset code 10
// RULE_07 - battery overvoltage stops switching when enabled
// RULE_08 - enabled bus undervoltage forces all gates off
// RULE_09 - bus fault latches off, retry every 500 ms
// RULE_10 - input undervoltage clears good flag, gate off
// RULE_11 - soft reset returns registers to defaults
// RULE_12 - fault latch clear releases latched-off state
// RULE_13 - loop status read-only regulation loop flags
// RULE_14 - status one shows thermal and charge flags
// RULE_15 - overvoltage flag shown whatever stop enable is
// RULE_16 - feedback short flagged only with external divider
// RULE_17 - port undervoltage flags only for charging ports
// RULE_18 - bus short flag latched until retry or clear
// RULE_19 - port a insertion always, b when discharging
// RULE_20 - input good only while port is charging
// RULE_21 - rising short/insert edge pulses unmasked interrupt
// RULE_22 - input good toggles pulse unmasked interrupt
// RULE_23 - host reaches registers as i2c target
// RULE_24 - interrupt pulse fixed width, edges merged
`timescale 1ns/1ps
module ccs_regs #(
	parameter int RETRY_CYC = ccs_pkg::RETRY_CYC
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               reset,
	// i2c pins
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	// mode and detectors
	input  wire ccs_pkg::ccs_mode_t  mode,
	input  wire ccs_pkg::ccs_sense_t sense,
	// converter controls
	output logic [9:0]              output_voltage_code,
	output logic [15:0]             vout_mv,
	output logic [7:0]              input_current_limit_code,
	output logic [1:0]              battery_current_limit,
	output logic                    switching_stop,
	output logic                    charge_terminate,
	output logic [2:0]              port_gate_force_off,
	// interrupt pin
	output logic                    int_n
);
	ccs_pkg::ccs_state_t state_ff;
	ccs_pkg::ccs_sense_t sense_ff;
	logic       scl_q_ff;
	logic       sda_q_ff;
	logic [7:0] shreg_ff;
	logic [3:0] cnt_ff;
	logic [7:0] ptr_ff;
	logic       first_ff;
	logic       rw_ff;
	logic       nack_ff;
	logic       wr_stb_ff;
	logic [7:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	logic       srst_ff;
	logic       rst_regs;
	logic [7:0] ilim_stg_ff;
	logic [7:0] vhigh_stg_ff;
	logic [1:0] vlow_stg_ff;
	logic [1:0] clamp_stg_ff;
	logic [1:0] clamp_app_ff;
	logic [7:0] ilim_app_ff;
	logic [9:0] vcode_ff;
	logic [1:0] bat_ff;
	logic [5:0] prot_ff;
	logic [4:0] mask_ff;
	logic       latch_off_ff;
	logic       short_flag_ff;
	logic [31:0] retry_cnt_ff;
	logic [4:0] intf_q_ff;
	logic [7:0] int_cnt_ff;
	logic       int_n_ff;
	logic [15:0] vout_mv_ff;
	logic [7:0] ilim_eff_ff;
	logic       start_c;
	logic       stop_c;
	logic       scl_rise;
	logic       scl_fall;
	logic       wr_v;
	logic       wr_i;
	logic       fclr;
	logic       bus_mode;
	logic       bus_fault;
	logic       uv_gate;
	logic       b_chg;
	logic       c_chg;
	logic       b_good;
	logic       c_good;
	logic       a_ins;
	logic       b_ins;
	logic [4:0] intf;
	logic [4:0] int_ev;
	logic [7:0] min_code;

	// register read decode
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		case (a)
			ccs_pkg::OFF_ILIM:  rd_mux = ilim_stg_ff;
			ccs_pkg::OFF_VLOW:  rd_mux = {6'h00, vlow_stg_ff};
			ccs_pkg::OFF_VHIGH: rd_mux = vhigh_stg_ff;
			ccs_pkg::OFF_CUR:   rd_mux = {4'h0, clamp_stg_ff, bat_ff};
			ccs_pkg::OFF_PROT:  rd_mux = {2'h0, prot_ff};
			ccs_pkg::OFF_LOOP:  rd_mux = {4'h0, sense_ff.loop_flags}; // [RULE_13]
			ccs_pkg::OFF_STATUS_ONE:  rd_mux = {2'h0, sense_ff.over_temp, sense_ff.therm_hot, // [RULE_14]
			                              sense_ff.therm_cool, sense_ff.therm_cold,
			                              sense_ff.end_of_charge, sense_ff.light_load};
			ccs_pkg::OFF_STATUS_TWO:  rd_mux = {1'h0, sense_ff.fb_short & mode.feedback_source_select, // [RULE_16]
			                              sense_ff.batt_ov, 3'h0, // [RULE_15]
			                              sense_ff.port_c_uv & c_chg, sense_ff.port_b_uv & b_chg}; // [RULE_17]
			ccs_pkg::OFF_INTF:  rd_mux = {3'h0, intf};
			ccs_pkg::OFF_MASK:  rd_mux = {3'h0, mask_ff};
			default:            rd_mux = 8'h00; // strobes read zero [RULE_04]
		endcase
	endfunction

	// pin conditions
	assign start_c  = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
	assign stop_c   = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
	assign scl_rise = scl_in & ~scl_q_ff;
	assign scl_fall = ~scl_in & scl_q_ff;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= scl_in;
			sda_q_ff <= sda_in;
		end
	end

	// i2c target protocol engine
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff   <= ccs_pkg::ST_IDLE;
			shreg_ff   <= 8'h00;
			cnt_ff     <= 4'h0;
			ptr_ff     <= 8'h00;
			first_ff   <= 1'b0;
			rw_ff      <= 1'b0;
			nack_ff    <= 1'b0;
			wr_stb_ff  <= 1'b0;
			wr_addr_ff <= 8'h00;
			wr_data_ff <= 8'h00;
		end else begin
			wr_stb_ff <= 1'b0;
			if (start_c) begin // [RULE_23]
				state_ff <= ccs_pkg::ST_ADDR;
				cnt_ff   <= 4'h0;
			end else if (stop_c) begin
				state_ff <= ccs_pkg::ST_IDLE;
			end else begin
				case (state_ff)
					ccs_pkg::ST_ADDR, ccs_pkg::ST_WBYTE: begin
						if (scl_rise && cnt_ff != 4'h8) begin
							shreg_ff <= {shreg_ff[6:0], sda_in};
							cnt_ff   <= cnt_ff + 4'h1;
						end else if (scl_fall && cnt_ff == 4'h8) begin
							if (state_ff == ccs_pkg::ST_ADDR) begin
								if (shreg_ff[7:1] == ccs_pkg::I2C_ADDR) begin
									state_ff <= ccs_pkg::ST_AACK;
									rw_ff    <= shreg_ff[0];
									first_ff <= 1'b1;
								end else begin
									state_ff <= ccs_pkg::ST_IDLE;
								end
							end else begin
								state_ff <= ccs_pkg::ST_WACK;
								first_ff <= 1'b0;
								if (first_ff) begin
									ptr_ff <= shreg_ff;
								end else begin
									wr_stb_ff  <= 1'b1;
									wr_addr_ff <= ptr_ff;
									wr_data_ff <= shreg_ff;
									ptr_ff     <= ptr_ff + 8'h01;
								end
							end
						end
					end
					ccs_pkg::ST_AACK, ccs_pkg::ST_WACK: begin
						if (scl_fall) begin
							cnt_ff <= 4'h0;
							if (state_ff == ccs_pkg::ST_AACK && rw_ff) begin
								state_ff <= ccs_pkg::ST_RBYTE;
								shreg_ff <= rd_mux(ptr_ff);
								ptr_ff   <= ptr_ff + 8'h01;
							end else begin
								state_ff <= ccs_pkg::ST_WBYTE;
							end
						end
					end
					ccs_pkg::ST_RBYTE: begin
						if (scl_fall) begin
							if (cnt_ff == 4'h7) begin
								state_ff <= ccs_pkg::ST_RACK;
								cnt_ff   <= 4'h0;
							end else begin
								shreg_ff <= {shreg_ff[6:0], 1'b0};
								cnt_ff   <= cnt_ff + 4'h1;
							end
						end
					end
					ccs_pkg::ST_RACK: begin
						if (scl_rise) begin
							nack_ff <= sda_in;
						end else if (scl_fall) begin
							if (nack_ff) begin
								state_ff <= ccs_pkg::ST_IDLE;
							end else begin
								state_ff <= ccs_pkg::ST_RBYTE;
								shreg_ff <= rd_mux(ptr_ff);
								ptr_ff   <= ptr_ff + 8'h01;
							end
						end
					end
					default: state_ff <= ccs_pkg::ST_IDLE;
				endcase
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = (state_ff == ccs_pkg::ST_AACK) || (state_ff == ccs_pkg::ST_WACK) ||
	                 ((state_ff == ccs_pkg::ST_RBYTE) && !shreg_ff[7]);

	// write strobe decode, never stored [RULE_04]
	assign wr_v = wr_stb_ff && wr_addr_ff == ccs_pkg::OFF_LOAD && wr_data_ff[ccs_pkg::LOAD_V_BIT];
	assign wr_i = wr_stb_ff && wr_addr_ff == ccs_pkg::OFF_LOAD && wr_data_ff[ccs_pkg::LOAD_I_BIT];
	assign fclr = wr_stb_ff && wr_addr_ff == ccs_pkg::OFF_CTRL && wr_data_ff[ccs_pkg::CTRL_FCLR_BIT];

	// soft reset one cycle after the write [RULE_11]
	always_ff @(posedge core_clk) begin
		if (reset) begin
			srst_ff <= 1'b0;
		end else begin
			srst_ff <= wr_stb_ff && wr_addr_ff == ccs_pkg::OFF_CTRL && wr_data_ff[ccs_pkg::CTRL_SRST_BIT];
		end
	end
	assign rst_regs = reset | srst_ff; // [RULE_11]

	// staging and plain registers
	always_ff @(posedge core_clk) begin
		if (rst_regs) begin
			ilim_stg_ff  <= ccs_pkg::RST_ILIM;
			vhigh_stg_ff <= ccs_pkg::RST_VHIGH;
			vlow_stg_ff  <= ccs_pkg::RST_VLOW;
			clamp_stg_ff <= ccs_pkg::RST_CLAMP; // [RULE_05]
			bat_ff       <= ccs_pkg::RST_BAT; // [RULE_06]
			prot_ff      <= ccs_pkg::RST_PROT;
			mask_ff      <= ccs_pkg::RST_MASK; // [RULE_21]
		end else if (wr_stb_ff) begin
			case (wr_addr_ff)
				ccs_pkg::OFF_ILIM:  ilim_stg_ff  <= wr_data_ff;
				ccs_pkg::OFF_VHIGH: vhigh_stg_ff <= wr_data_ff;
				ccs_pkg::OFF_VLOW:  vlow_stg_ff  <= wr_data_ff[1:0];
				ccs_pkg::OFF_CUR: begin
					clamp_stg_ff <= wr_data_ff[3:2];
					bat_ff       <= wr_data_ff[1:0];
				end
				ccs_pkg::OFF_PROT:  prot_ff      <= wr_data_ff[5:0];
				ccs_pkg::OFF_MASK:  mask_ff      <= wr_data_ff[4:0];
				default: ;
			endcase
		end
	end

	// applied copies, updated only by load strobes
	always_ff @(posedge core_clk) begin
		if (rst_regs) begin
			vcode_ff     <= {ccs_pkg::RST_VHIGH, ccs_pkg::RST_VLOW};
			ilim_app_ff  <= ccs_pkg::RST_ILIM;
			clamp_app_ff <= ccs_pkg::RST_CLAMP;
		end else begin
			if (wr_v) begin
				vcode_ff <= {vhigh_stg_ff, vlow_stg_ff}; // [RULE_02]
			end
			if (wr_i) begin
				ilim_app_ff  <= ilim_stg_ff; // [RULE_03]
				clamp_app_ff <= clamp_stg_ff;
			end
		end
	end

	// converter setpoints
	assign min_code = ccs_pkg::CLAMP_BASE_CD + 8'(clamp_app_ff) * ccs_pkg::CLAMP_STEP_CD;
	always_ff @(posedge core_clk) begin
		if (rst_regs) begin
			vout_mv_ff  <= ccs_pkg::VOUT_BASE_MV;
			ilim_eff_ff <= ccs_pkg::RST_ILIM;
		end else begin
			vout_mv_ff  <= mode.feedback_source_select ? 16'h0000 : // [RULE_01]
			               ccs_pkg::VOUT_BASE_MV + 16'(vcode_ff) * ccs_pkg::VOUT_STEP_MV;
			ilim_eff_ff <= (ilim_app_ff < min_code) ? min_code : ilim_app_ff; // [RULE_05]
		end
	end

	// detector sampling
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sense_ff <= '0;
		end else begin
			sense_ff <= sense;
		end
	end

	// bus fault protection
	assign bus_mode  = mode.discharge | mode.pass_through;
	assign uv_gate   = sense_ff.bus_uv & prot_ff[ccs_pkg::PROT_UV_BIT]; // [RULE_08]
	assign bus_fault = bus_mode & (sense_ff.bus_short | uv_gate); // [RULE_09]
	always_ff @(posedge core_clk) begin
		if (rst_regs) begin
			latch_off_ff  <= 1'b0;
			short_flag_ff <= 1'b0;
			retry_cnt_ff  <= 32'h0;
		end else begin
			if (bus_fault || uv_gate) begin
				latch_off_ff <= 1'b1; // set wins over clear [RULE_08]
				retry_cnt_ff <= 32'h0;
			end else if (fclr) begin
				latch_off_ff <= 1'b0; // [RULE_12]
				retry_cnt_ff <= 32'h0;
			end else if (latch_off_ff && prot_ff[ccs_pkg::PROT_RTR_BIT]) begin
				if (retry_cnt_ff == 32'(RETRY_CYC - 1)) begin
					latch_off_ff <= 1'b0; // [RULE_09]
					retry_cnt_ff <= 32'h0;
				end else begin
					retry_cnt_ff <= retry_cnt_ff + 32'h1;
				end
			end
			if (bus_fault) begin
				short_flag_ff <= 1'b1; // [RULE_18]
			end else if (fclr || (latch_off_ff && prot_ff[ccs_pkg::PROT_RTR_BIT] &&
			             retry_cnt_ff == 32'(RETRY_CYC - 1))) begin
				short_flag_ff <= 1'b0; // [RULE_18]
			end
		end
	end

	// port status
	assign b_chg  = ~mode.port_b_direction;
	assign c_chg  = ~mode.port_c_direction;
	assign b_good = b_chg & ~(sense_ff.port_b_uv & prot_ff[ccs_pkg::PROT_INUV_BIT]); // [RULE_20]
	assign c_good = c_chg & ~(sense_ff.port_c_uv & prot_ff[ccs_pkg::PROT_INUV_BIT]); // [RULE_10]
	assign a_ins  = sense_ff.port_a_insert; // [RULE_19]
	assign b_ins  = sense_ff.port_b_insert & mode.port_b_direction; // [RULE_19]
	assign intf   = {short_flag_ff, b_ins, a_ins, c_good, b_good};

	// interrupt edges and pulse
	assign int_ev = {intf[4:2] & ~intf_q_ff[4:2], intf[1:0] ^ intf_q_ff[1:0]} & ~mask_ff; // [RULE_21] [RULE_22]
	always_ff @(posedge core_clk) begin
		if (rst_regs) begin
			intf_q_ff  <= intf; // no false edge after reset
			int_cnt_ff <= 8'h00;
			int_n_ff   <= 1'b1;
		end else begin
			intf_q_ff <= intf;
			if (int_cnt_ff != 8'h00) begin
				int_cnt_ff <= int_cnt_ff - 8'h01; // edges merged [RULE_24]
			end else if (|int_ev) begin
				int_cnt_ff <= ccs_pkg::INT_PULSE_CYC;
			end
			int_n_ff <= !(((|int_ev) && int_cnt_ff == 8'h00) || int_cnt_ff > 8'h01); // [RULE_24]
		end
	end

	// outputs
	assign output_voltage_code      = vcode_ff;
	assign vout_mv                  = vout_mv_ff;
	assign input_current_limit_code = ilim_eff_ff;
	assign battery_current_limit    = bat_ff; // [RULE_06]
	assign switching_stop           = sense_ff.batt_ov & prot_ff[ccs_pkg::PROT_OVP_BIT]; // [RULE_07]
	assign charge_terminate         = sense_ff.end_of_charge & ~mode.termination_disable; // [RULE_14]
	assign port_gate_force_off[0]   = latch_off_ff; // [RULE_09]
	assign port_gate_force_off[1]   = latch_off_ff | (b_chg & ~b_good); // [RULE_10]
	assign port_gate_force_off[2]   = latch_off_ff | (c_chg & ~c_good); // [RULE_10]
	assign int_n                    = int_n_ff;
endmodule

// file: logic/ccs_pkg.sv
// charger control/status register bank: shared constants and types
// assumes a 50 MHz core clock and an i2c host on the register pins
package ccs_pkg;
	// i2c target address, value arbitrary
	localparam logic [6:0] I2C_ADDR       = 7'h3A;
	// register offsets
	localparam logic [7:0] OFF_ILIM       = 8'h06;
	localparam logic [7:0] OFF_VLOW       = 8'h07;
	localparam logic [7:0] OFF_LOAD       = 8'h08;
	localparam logic [7:0] OFF_VHIGH      = 8'h09;
	localparam logic [7:0] OFF_CUR        = 8'h0A;
	localparam logic [7:0] OFF_PROT       = 8'h0B;
	localparam logic [7:0] OFF_CTRL       = 8'h0C;
	localparam logic [7:0] OFF_LOOP       = 8'h0D;
	localparam logic [7:0] OFF_STATUS_ONE       = 8'h0E;
	localparam logic [7:0] OFF_STATUS_TWO       = 8'h0F;
	localparam logic [7:0] OFF_INTF       = 8'h10;
	localparam logic [7:0] OFF_MASK       = 8'h11;
	// reset values
	localparam logic [7:0] RST_ILIM       = 8'h12;
	localparam logic [7:0] RST_VHIGH      = 8'h00;
	localparam logic [1:0] RST_VLOW       = 2'h0;
	localparam logic [1:0] RST_CLAMP      = 2'h0;
	localparam logic [1:0] RST_BAT        = 2'h2;
	localparam logic [5:0] RST_PROT       = 6'h1D;
	localparam logic [4:0] RST_MASK       = 5'h00;
	// field positions
	localparam int         LOAD_V_BIT     = 0;
	localparam int         LOAD_I_BIT     = 1;
	localparam int         CTRL_FCLR_BIT  = 0;
	localparam int         CTRL_SRST_BIT  = 2;
	localparam int         PROT_OVP_BIT   = 5;
	localparam int         PROT_UV_BIT    = 4;
	localparam int         PROT_RTR_BIT   = 3;
	localparam int         PROT_INUV_BIT  = 2;
	// output voltage and clamp scaling
	localparam logic [15:0] VOUT_BASE_MV  = 16'h1388;
	localparam logic [15:0] VOUT_STEP_MV  = 16'h000A;
	localparam logic [7:0]  CLAMP_BASE_CD = 8'h06;
	localparam logic [7:0]  CLAMP_STEP_CD = 8'h02;
	// timing
	localparam int          CLK_NS        = 20;
	localparam int          CLK_KHZ       = 50000;
	localparam int          RETRY_MS      = 500;
	localparam int          RETRY_CYC     = CLK_KHZ * RETRY_MS;
	localparam int          INT_PULSE_NS  = 1000;
	localparam logic [7:0]  INT_PULSE_CYC = 8'(INT_PULSE_NS / CLK_NS);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_ADDR   = 3'h1,
		ST_AACK   = 3'h3,
		ST_WBYTE  = 3'h2,
		ST_WACK   = 3'h6,
		ST_RBYTE  = 3'h7,
		ST_RACK   = 3'h5
	} ccs_state_t;

	// operating mode from the lower control registers
	typedef struct packed {
		logic discharge;
		logic pass_through;
		logic port_b_direction;
		logic port_c_direction;
		logic feedback_source_select;
		logic termination_disable;
	} ccs_mode_t;

	// detector levels from the analog side
	typedef struct packed {
		logic [3:0] loop_flags;
		logic       over_temp;
		logic       therm_hot;
		logic       therm_cool;
		logic       therm_cold;
		logic       end_of_charge;
		logic       light_load;
		logic       fb_short;
		logic       batt_ov;
		logic       bus_short;
		logic       bus_uv;
		logic       port_c_uv;
		logic       port_b_uv;
		logic       port_a_insert;
		logic       port_b_insert;
	} ccs_sense_t;
endpackage

// file: tb/ccs_regs_monitor.sv
// checker for the charger register bank ports
// bound to ccs_regs from the bench top; sees ports only
`timescale 1ns/1ps
module ccs_regs_monitor #(
	parameter int RETRY_CYC = 20
) (
	// clock and reset
	input wire logic                core_clk,
	input wire logic                reset,
	// i2c pins
	input wire logic                scl_in,
	input wire logic                sda_in,
	input wire logic                sda_out,
	input wire logic                sda_oe,
	// mode and detectors
	input wire ccs_pkg::ccs_mode_t  mode,
	input wire ccs_pkg::ccs_sense_t sense,
	// converter controls
	input wire logic [9:0]          output_voltage_code,
	input wire logic [15:0]         vout_mv,
	input wire logic [7:0]          input_current_limit_code,
	input wire logic [1:0]          battery_current_limit,
	input wire logic                switching_stop,
	input wire logic                charge_terminate,
	input wire logic [2:0]          port_gate_force_off,
	// interrupt pin
	input wire logic                int_n
);
	logic [7:0] low_cnt_ff;

	// length of the current interrupt pulse
	always_ff @(posedge core_clk) begin
		if (reset || int_n) begin
			low_cnt_ff <= 8'h00;
		end else begin
			low_cnt_ff <= low_cnt_ff + 8'h01;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_int_width: assert property ($rose(int_n) |-> low_cnt_ff == 8'h32)
		else $error("interrupt pulse width wrong");
	a_int_bound: assert property (low_cnt_ff <= 8'h32)
		else $error("interrupt pulse too long");
	a_gate_bus: assert property (mode.discharge && sense.bus_short |-> ##2 port_gate_force_off == 3'h7)
		else $error("gates not forced off on bus short");
	a_vout_calc: assert property (!mode.feedback_source_select && $past(!mode.feedback_source_select)
		|-> vout_mv == 16'h1388 + 16'h000A * $past(output_voltage_code))
		else $error("output voltage not 5 V plus 10 mV per code");
	a_vout_ext: assert property (mode.feedback_source_select && $past(mode.feedback_source_select)
		|-> vout_mv == 16'h0000)
		else $error("output voltage set while external divider chosen");
	a_term_flag: assert property (charge_terminate == ($past(sense.end_of_charge) && !mode.termination_disable))
		else $error("charge termination wrong");
	a_ilim_floor: assert property (input_current_limit_code >= 8'h06)
		else $error("current limit below lowest clamp");
	a_ov_stop: assert property (switching_stop |-> $past(sense.batt_ov))
		else $error("switching stopped without overvoltage");
endmodule

// file: tb/ccs_host.sv
// host microcontroller model: i2c master for the register bank
// assumes sda has a pull-up; scl moves on falling core_clk edges
`timescale 1ns/1ps
module ccs_host (
	// clock
	input wire logic core_clk,
	// i2c wires
	output logic     scl,
	output logic     sda_oe,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	task automatic tk(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// one bit: drive b (1 = release), sample wire while scl high
	task automatic bit_io(input logic b, output logic r);
		sda_oe = ~b;
		tk(2);
		scl = 1'b1;
		tk(2);
		r = sda;
		tk(2);
		scl = 1'b0;
		tk(2);
	endtask

	task automatic start();
		sda_oe = 1'b0;
		tk(2);
		scl = 1'b1;
		tk(2);
		sda_oe = 1'b1;
		tk(2);
		scl = 1'b0;
		tk(2);
	endtask

	task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic r9);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r9);
			q[i] = r9;
		end
		bit_io(1'b1, r9);
	endtask

	// single register access with byte offset, read uses repeated start
	task automatic acc(input logic [6:0] dev, input logic rd, input logic [7:0] off,
	                   input logic [7:0] wd, output logic [7:0] rdat, output logic ok);
		logic [7:0] q;
		logic       r;
		start();
		xb({dev, 1'b0}, q, r);
		ok = ~r;
		xb(off, q, r);
		ok = ok & ~r;
		rdat = 8'h00;
		if (rd) begin
			start();
			xb({dev, 1'b1}, q, r);
			ok = ok & ~r;
			xb(8'hFF, rdat, r);
		end else begin
			xb(wd, q, r);
			ok = ok & ~r;
		end
		sda_oe = 1'b1;
		tk(2);
		scl = 1'b1;
		tk(2);
		sda_oe = 1'b0;
		tk(4);
	endtask
endmodule

// file: tb/ccs_regs_tb.sv
// bench for the charger register bank with an i2c host model
// drives mode and detector levels on falling clock edges
`timescale 1ns/1ps
module ccs_regs_tb;
	logic                core_clk = 1'b0;
	logic                reset;
	logic                scl;
	logic                host_oe;
	logic                sda_out;
	logic                sda_oe;
	logic                sda_w;
	ccs_pkg::ccs_mode_t  mode;
	ccs_pkg::ccs_sense_t sense;
	logic [9:0]          vcode;
	logic [15:0]         vout;
	logic [7:0]          ilim;
	logic [1:0]          blim;
	logic                stop;
	logic                term;
	logic [2:0]          gates;
	logic                int_n;
	int                  failures = 0;
	int                  tests_run = 0;

	always #10 core_clk = ~core_clk;
	assign sda_w = ~(host_oe | (sda_oe & ~sda_out));

	ccs_regs #(.RETRY_CYC(20)) i_ccs_regs (.core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .mode(mode), .sense(sense), .output_voltage_code(vcode),
		.vout_mv(vout), .input_current_limit_code(ilim), .battery_current_limit(blim), .switching_stop(stop),
		.charge_terminate(term), .port_gate_force_off(gates), .int_n(int_n));
	ccs_host i_ccs_host (.core_clk(core_clk), .scl(scl), .sda_oe(host_oe), .sda(sda_w));

	task automatic cy(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       ok;
		i_ccs_host.acc(ccs_pkg::I2C_ADDR, 1'b0, a, d, q, ok);
		chk($sformatf("write ack %h", a), 16'h0001, {15'h0000, ok});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic       ok;
		i_ccs_host.acc(ccs_pkg::I2C_ADDR, 1'b1, a, 8'h00, q, ok);
		chk($sformatf("reg %h", a), {7'h00, 1'b1, e}, {7'h00, ok, q});
	endtask

	task automatic pulse(input logic e);
		int w;
		int n;
		w = 0;
		n = 0;
		while (int_n === 1'b1 && w < 8) begin
			cy(1);
			w++;
		end
		while (int_n === 1'b0 && n < 60) begin
			cy(1);
			n++;
		end
		chk("int pulse length", e ? 16'h0032 : 16'h0000, 16'(n));
	endtask

	task automatic t_reset();
		logic [7:0] q;
		logic       ok;
		chk("int idle", 16'h0001, {15'h0000, int_n});
		rd(8'h06, 8'h12);
		rd(8'h07, 8'h00);
		rd(8'h0A, 8'h02);
		rd(8'h0B, 8'h1D);
		rd(8'h11, 8'h00);
		rd(8'h20, 8'h00);
		i_ccs_host.acc(ccs_pkg::I2C_ADDR ^ 7'h01, 1'b0, 8'h11, 8'h1F, q, ok);
		chk("foreign address ack", 16'h0000, {15'h0000, ok});
		chk("reset outputs", {6'h00, 10'h000}, {6'h00, vcode});
		chk("reset vout", 16'h1388, vout);
		$display("t_reset done");
	endtask

	task automatic t_soft();
		wr(8'h11, 8'h1F);
		wr(8'h0B, 8'h00);
		wr(8'h0A, 8'h03);
		chk("battery limit", 16'h0003, {14'h0000, blim});
		wr(8'h0C, 8'h04);
		chk("int idle", 16'h0001, {15'h0000, int_n});
		rd(8'h11, 8'h00);
		rd(8'h0B, 8'h1D);
		rd(8'h0C, 8'h00);
		chk("battery limit", 16'h0002, {14'h0000, blim});
		$display("t_soft done");
	endtask

	task automatic t_load();
		wr(8'h09, 8'h10);
		wr(8'h07, 8'h01);
		chk("staged code", 16'h0000, {6'h00, vcode});
		wr(8'h08, 8'h01);
		chk("loaded code", 16'h0041, {6'h00, vcode});
		chk("vout", 16'h1612, vout);
		rd(8'h08, 8'h00);
		mode.feedback_source_select = 1'b1;
		cy(3);
		chk("vout external", 16'h0000, vout);
		mode.feedback_source_select = 1'b0;
		wr(8'h06, 8'h03);
		chk("ilim staged", 16'h0012, {8'h00, ilim});
		for (int c = 0; c < 4; c++) begin
			wr(8'h0A, 8'(c * 5));
			chk("battery limit", 16'(c), {14'h0000, blim});
			wr(8'h08, 8'h02);
			chk("ilim clamp", 16'(6 + 2 * c), {8'h00, ilim});
		end
		wr(8'h06, 8'h20);
		wr(8'h08, 8'h02);
		chk("ilim loaded", 16'h0020, {8'h00, ilim});
		$display("t_load done");
	endtask

	task automatic t_irq();
		sense.port_a_insert = 1'b1;
		pulse(1'b1);
		rd(8'h10, 8'h07);
		wr(8'h11, 8'h09);
		mode.port_b_direction = 1'b1;
		sense.port_b_insert = 1'b1;
		pulse(1'b0);
		sense.port_c_uv = 1'b1;
		pulse(1'b1);
		chk("gate c", 16'h0004, {13'h0000, gates});
		rd(8'h0F, 8'h02);
		rd(8'h10, 8'h0C);
		sense.port_c_uv = 1'b0;
		cy(2);
		sense.port_c_uv = 1'b1;
		pulse(1'b1);
		pulse(1'b0);
		sense.port_c_uv = 1'b0;
		pulse(1'b1);
		$display("t_irq done");
	endtask

	task automatic t_bus();
		mode.discharge = 1'b1;
		wr(8'h0B, 8'h15);
		sense.bus_short = 1'b1;
		cy(3);
		sense.bus_short = 1'b0;
		chk("gates short", 16'h0007, {13'h0000, gates});
		cy(40);
		chk("gates latched", 16'h0007, {13'h0000, gates});
		rd(8'h10, 8'h1E);
		wr(8'h0C, 8'h01);
		chk("gates released", 16'h0000, {13'h0000, gates});
		rd(8'h10, 8'h0E);
		wr(8'h0B, 8'h1D);
		mode.discharge = 1'b0;
		mode.pass_through = 1'b1;
		sense.bus_uv = 1'b1;
		pulse(1'b1);
		sense.bus_uv = 1'b0;
		chk("gates uv", 16'h0007, {13'h0000, gates});
		cy(30);
		chk("gates retry", 16'h0000, {13'h0000, gates});
		rd(8'h10, 8'h0E);
		$display("t_bus done");
	endtask

	task automatic t_stat();
		sense.loop_flags = 4'hA;
		sense.therm_hot = 1'b1;
		sense.batt_ov = 1'b1;
		sense.end_of_charge = 1'b1;
		cy(3);
		chk("stop off", 16'h0000, {15'h0000, stop});
		chk("terminate", 16'h0001, {15'h0000, term});
		rd(8'h0D, 8'h0A);
		rd(8'h0E, 8'h12);
		rd(8'h0F, 8'h20);
		wr(8'h0B, 8'h3D);
		chk("stop on", 16'h0001, {15'h0000, stop});
		rd(8'h0F, 8'h20);
		sense.fb_short = 1'b1;
		rd(8'h0F, 8'h20);
		mode.feedback_source_select = 1'b1;
		rd(8'h0F, 8'h60);
		mode.feedback_source_select = 1'b0;
		mode.termination_disable = 1'b1;
		sense.batt_ov = 1'b0;
		cy(3);
		chk("stop cleared", 16'h0000, {15'h0000, stop});
		chk("terminate off", 16'h0000, {15'h0000, term});
		$display("t_stat done");
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		reset = 1'b1;
		mode = '0;
		sense = '0;
		cy(12);
		reset = 1'b0;
		cy(5);
		t_reset();
		t_soft();
		t_load();
		t_irq();
		t_bus();
		t_stat();
		conclude();
	end

	initial begin
		repeat (90000) @(posedge core_clk);
		failures++;
		conclude();
	end
endmodule

bind ccs_regs ccs_regs_monitor #(.RETRY_CYC(RETRY_CYC)) i_ccs_regs_monitor (.core_clk, .reset, .scl_in, .sda_in,
	.sda_out, .sda_oe, .mode, .sense, .output_voltage_code, .vout_mv, .input_current_limit_code,
	.battery_current_limit, .switching_stop, .charge_terminate, .port_gate_force_off, .int_n);
